// [inc/lpc_pkg.sv]
// Constants and types for the low power mode controller.
// Assumes one system clock domain and a synchronous active-high reset.
// Behaviour
// - Leave sleep or all-module clock stop on an interrupt, then service it
// - Keep the full-speed USB clock available during sleep
// - Sleep keeps independent watchdog and oscillator; system watchdog halts
// - Both eight-bit timers and the real-time clock keep running in sleep
// - Voltage detector and power-on reset circuit never gated by sleep entry
// - All RAMs retained and accessible, flash and ports operate in sleep
// - Port output cutoff and peripherals operate in sleep; only core and system watchdog halt
package lpc_pkg;

    // ----------------------------------------
    // Modes and states
    // ----------------------------------------
    typedef enum logic [1:0]
    {
        LPC_RUN     = 2'h0,
        LPC_ENTER   = 2'h1,
        LPC_LOW     = 2'h3,
        LPC_WAKE    = 2'h2
    } lpc_state_t;

    localparam logic LPC_MODE_SLEEP    = 1'h0;
    localparam logic LPC_MODE_ALLSTOP  = 1'h1;

    // ----------------------------------------
    // Clock gate enable vector bit positions
    // ----------------------------------------
    localparam int LPC_G_CORE      = 0;
    localparam int LPC_G_USB       = 1;
    localparam int LPC_G_SYSWDT    = 2;
    localparam int LPC_G_INDEPENDENT_WATCHDOG      = 3;
    localparam int LPC_G_TMR       = 4;
    localparam int LPC_G_RTC       = 5;
    localparam int LPC_G_VDET      = 6;
    localparam int LPC_G_POR       = 7;
    localparam int LPC_G_RAM       = 8;
    localparam int LPC_G_FLASH     = 9;
    localparam int LPC_G_PORTS     = 10;
    localparam int LPC_G_CUTOFF    = 11;
    localparam int LPC_G_PERIPH    = 12;
    localparam int LPC_G_WIDTH     = 13;
    localparam int LPC_OSC_WIDTH   = 7;

    // Reset values: everything enabled, all oscillators allowed
    localparam logic [12:0] LPC_GATE_RST = 13'h1fff;
    localparam logic [6:0]  LPC_OSC_RST  = 7'h7f;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int LPC_CLK_MHZ       = 40;
    localparam int LPC_SETTLE_NS     = 50;
    localparam int LPC_SETTLE_CYC    =
        (LPC_SETTLE_NS * LPC_CLK_MHZ + 999) / 1000;

endpackage

// [core/lpc_sync.sv]
// Three-stage synchroniser with agreement filter for pin-domain inputs.
// Assumes the destination runs on ref_clk; output changes once the
// second and third stages agree.
`timescale 1ns/100ps
module lpc_sync #(
    parameter int WIDTH = 1
)
(
    // Clock and control
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    typedef struct packed
    {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } lpc_sync_st_t;

    lpc_sync_st_t st_ff;
    lpc_sync_st_t nxt_st;

    always_comb
    begin
        nxt_st    = st_ff;
        nxt_st.s1 = din;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (st_ff.s2[i] == st_ff.s3[i])
            begin
                nxt_st.q[i] = st_ff.s3[i];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_ff <= '0;
        end
        else if (clk_en)
        begin
            st_ff <= nxt_st;
        end
    end

    assign dout = st_ff.q;

endmodule

// [core/lpc_ctrl.sv]
// Low power mode controller: sleep and all-module clock stop.
// Assumes the core raises a one-cycle entry request on ref_clk and that
// wake interrupts arrive asynchronously from pins or other domains.
// Standby modes are out of scope; a request outside the idle state is
// dropped without notice, so the core must wait for the wake pulse.
// All outputs are registered.
`timescale 1ns/100ps
module lpc_ctrl #(
    parameter int IRQ_W = 8
)
(
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    input  wire logic                        clk_en,
    // Core request side
    input  wire logic                        lp_req,
    input  wire logic                        lp_mode,
    input  wire logic [IRQ_W-1:0]            irq_pin,
    // Status to core
    output logic                             core_halted,
    output logic                             wake_irq,
    output logic                             in_sleep,
    output logic                             in_allstop,
    // Clock domain enables
    output logic [lpc_pkg::LPC_G_WIDTH-1:0]  gate_en,
    output logic [lpc_pkg::LPC_OSC_WIDTH-1:0] osc_allow
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    // cnt loads SETTLE on a request in run and counts only in the entry state; elsewhere it keeps its last value
    typedef struct packed
    {
        lpc_pkg::lpc_state_t                  state;
        logic                                 mode;
        logic [3:0]                           cnt;
        logic                                 halted;
        logic                                 wake;
        logic                                 sleep;
        logic                                 allstop;
        logic [lpc_pkg::LPC_G_WIDTH-1:0]      gate;
        logic [lpc_pkg::LPC_OSC_WIDTH-1:0]    osc;
    } lpc_st_t;

    // Four bits are plenty here; a longer settle time needs a wider count
    localparam logic [3:0] SETTLE =
        4'(lpc_pkg::LPC_SETTLE_CYC);

    lpc_st_t          st_ff;
    lpc_st_t          nxt_st;
    logic [IRQ_W-1:0] irq_sync;
    logic             wake_any;

    // ----------------------------------------
    // Wake synchroniser
    // ----------------------------------------
    // Costs four cycles of wake latency, buys freedom from metastability
    lpc_sync #(
        .WIDTH (IRQ_W)
    ) u_irq_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .din     (irq_pin),
        .dout    (irq_sync)
    );

    // Any line wakes; masking is left to the interrupt controller
    assign wake_any = |irq_sync;

    // ----------------------------------------
    // Gate pattern per mode
    // ----------------------------------------
    function automatic logic [lpc_pkg::LPC_G_WIDTH-1:0] gates_for(
        input logic low,
        input logic mode
    );
        logic [lpc_pkg::LPC_G_WIDTH-1:0] g;
        g = lpc_pkg::LPC_GATE_RST;
        if (low)
        begin
            g[lpc_pkg::LPC_G_CORE]   = 1'b0;
            g[lpc_pkg::LPC_G_SYSWDT] = 1'b0;
            // Sleep keeps USB, RAM, flash, ports, cutoff, peripherals
            // Ports and cutoff stay on in both modes so pin states hold
            if (mode == lpc_pkg::LPC_MODE_ALLSTOP)
            begin
                g[lpc_pkg::LPC_G_USB]    = 1'b0;
                g[lpc_pkg::LPC_G_RAM]    = 1'b0;
                g[lpc_pkg::LPC_G_FLASH]  = 1'b0;
                g[lpc_pkg::LPC_G_PERIPH] = 1'b0;
            end
            else
            begin
                g[lpc_pkg::LPC_G_USB]    = 1'b1;
                g[lpc_pkg::LPC_G_RAM]    = 1'b1;
                g[lpc_pkg::LPC_G_FLASH]  = 1'b1;
                g[lpc_pkg::LPC_G_PORTS]  = 1'b1;
                g[lpc_pkg::LPC_G_CUTOFF] = 1'b1;
                g[lpc_pkg::LPC_G_PERIPH] = 1'b1;
            end
            // Always on: INDEPENDENT_WATCHDOG, timers, RTC, detector, POR
            g[lpc_pkg::LPC_G_INDEPENDENT_WATCHDOG] = 1'b1;
            g[lpc_pkg::LPC_G_TMR]  = 1'b1;
            g[lpc_pkg::LPC_G_RTC]  = 1'b1;
            g[lpc_pkg::LPC_G_VDET] = 1'b1;
            g[lpc_pkg::LPC_G_POR]  = 1'b1;
        end
        return g;
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.wake = 1'b0;
        // Neither mode stops an oscillator or a PLL
        nxt_st.osc  = lpc_pkg::LPC_OSC_RST;
        case (st_ff.state)
            lpc_pkg::LPC_RUN:
            begin
                // Mode is latched here; lp_mode is ignored at other times
                if (lp_req)
                begin
                    nxt_st.mode  = lp_mode;
                    nxt_st.cnt   = SETTLE;
                    nxt_st.state = lpc_pkg::LPC_ENTER;
                end
            end
            lpc_pkg::LPC_ENTER:
            begin
                // Core clock gated only after pipelines drain
                if (st_ff.cnt <= 4'h1)
                begin
                    // Flags and gates move on the same edge as the halt
                    nxt_st.state   = lpc_pkg::LPC_LOW;
                    nxt_st.halted  = 1'b1;
                    nxt_st.sleep   =
                        (st_ff.mode == lpc_pkg::LPC_MODE_SLEEP);
                    nxt_st.allstop =
                        (st_ff.mode == lpc_pkg::LPC_MODE_ALLSTOP);
                    nxt_st.gate    = gates_for(1'b1, st_ff.mode);
                end
                else
                begin
                    // Count down the drain time
                    nxt_st.cnt = st_ff.cnt - 4'h1;
                end
            end
            lpc_pkg::LPC_LOW:
            begin
                // Either mode holds the core until a synchronised interrupt
                if (wake_any)
                begin
                    // Restore clocks first, core resumes next cycle
                    nxt_st.gate    = gates_for(1'b0, st_ff.mode);
                    nxt_st.sleep   = 1'b0;
                    nxt_st.allstop = 1'b0;
                    nxt_st.state   = lpc_pkg::LPC_WAKE;
                end
            end
            lpc_pkg::LPC_WAKE:
            begin
                // Gates came back one edge earlier, so clocks are stable
                // Core restarts straight into interrupt service
                nxt_st.halted = 1'b0;
                nxt_st.wake   = 1'b1;
                nxt_st.state  = lpc_pkg::LPC_RUN;
            end
            default:
            begin
                // Unreachable code: recover to run with every clock on
                nxt_st.state   = lpc_pkg::LPC_RUN;
                nxt_st.halted  = 1'b0;
                nxt_st.sleep   = 1'b0;
                nxt_st.allstop = 1'b0;
                nxt_st.gate    = lpc_pkg::LPC_GATE_RST;
            end
        endcase
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Clock enable low freezes every field, the synchroniser included
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_ff.state   <= lpc_pkg::LPC_RUN;
            st_ff.mode    <= lpc_pkg::LPC_MODE_SLEEP;
            st_ff.cnt     <= 4'h0;
            st_ff.halted  <= 1'b0;
            st_ff.wake    <= 1'b0;
            st_ff.sleep   <= 1'b0;
            st_ff.allstop <= 1'b0;
            st_ff.gate    <= lpc_pkg::LPC_GATE_RST;
            st_ff.osc     <= lpc_pkg::LPC_OSC_RST;
        end
        else if (clk_en)
        begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Each output is a direct copy of a register field
    assign core_halted = st_ff.halted;
    assign wake_irq    = st_ff.wake;
    assign in_sleep    = st_ff.sleep;
    assign in_allstop  = st_ff.allstop;
    assign gate_en     = st_ff.gate;
    assign osc_allow   = st_ff.osc;

endmodule

// [sim/lpc_ctrl_monitor.sv]
// Port checker for the low power mode controller.
// Assumes a bind to lpc_ctrl, one clock, rst sync active high.
`timescale 1ns/100ps
module lpc_ctrl_monitor #(
    parameter int IRQ_W = 8
)
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Status and enables
    input wire logic        core_halted,
    input wire logic        wake_irq,
    input wire logic        in_sleep,
    input wire logic        in_allstop,
    input wire logic [12:0] gate_en,
    input wire logic [6:0]  osc_allow
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_core;
        (in_sleep || in_allstop) |-> core_halted && !gate_en[0];
    endproperty
    a_core: assert property (p_core) else $error("core clock on");
    property p_usb;
        in_sleep |-> gate_en[1] && !in_allstop;
    endproperty
    a_usb: assert property (p_usb) else $error("usb gated");
    property p_wdt;
        (in_sleep || in_allstop) |-> !gate_en[2] && gate_en[3];
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog gating");
    property p_tmr;
        (in_sleep || in_allstop) |-> gate_en[5:4] == 2'h3;
    endproperty
    a_tmr: assert property (p_tmr) else $error("timer gated");
    property p_vdet;
        gate_en[7:6] == 2'h3;
    endproperty
    a_vdet: assert property (p_vdet) else $error("detector gated");
    property p_ram;
        in_sleep |-> gate_en[10:8] == 3'h7;
    endproperty
    a_ram: assert property (p_ram) else $error("memory gated");
    property p_periph;
        in_sleep |-> gate_en[12:11] == 2'h3;
    endproperty
    a_periph: assert property (p_periph) else $error("periph gated");
    property p_osc;
        osc_allow == 7'h7f;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator stopped");
    property p_wake;
        $fell(core_halted) |-> wake_irq && $past(gate_en) == 13'h1fff;
    endproperty
    a_wake: assert property (p_wake) else $error("bad resume");
    property p_pulse;
        wake_irq |-> !core_halted ##1 !wake_irq;
    endproperty
    a_pulse: assert property (p_pulse) else $error("wake pulse");
endmodule

bind lpc_ctrl lpc_ctrl_monitor #(.IRQ_W(IRQ_W)) u_mon (
    .ref_clk(ref_clk), .rst(rst), .core_halted(core_halted),
    .wake_irq(wake_irq), .in_sleep(in_sleep), .in_allstop(in_allstop),
    .gate_en(gate_en), .osc_allow(osc_allow));

// [sim/lpc_core_model.sv]
// Core model: raises entry requests and wake interrupts.
// Assumes the bench calls its tasks; irq lines pulled low.
`timescale 1ns/100ps
module lpc_core_model (
    input  wire logic  ref_clk,
    input  wire logic  wake_irq,
    output logic       lp_req,
    output logic       lp_mode,
    output logic [7:0] irq_pin
);
    initial {lp_req, lp_mode, irq_pin} = 10'h000;
    task automatic request(input logic m);
        @(negedge ref_clk) {lp_req, lp_mode} = {1'b1, m};
        @(negedge ref_clk) lp_req = 1'b0;
    endtask
    task automatic wake(input logic [7:0] v);
        @(negedge ref_clk) irq_pin = v;
    endtask
    // Serviced interrupt drops, line falls to its pull-down
    always @(posedge ref_clk) if (wake_irq) irq_pin <= 8'h00;
endmodule

// [sim/low_power_mode_controller_test.sv]
// Self-checking bench for lpc_ctrl with a core model.
// Assumes 40 MHz ref_clk and sync active-high rst.
`timescale 1ns/100ps
module low_power_mode_controller_test;
    logic        ref_clk, rst, clk_en, lp_req, lp_mode, m;
    logic        core_halted, wake_irq, in_sleep, in_allstop;
    logic [7:0]  irq_pin, v;
    logic [12:0] gate_en;
    logic [6:0]  osc_allow;
    int          fail_count, tests_run, cycles, seed, i, n;
    lpc_ctrl #(.IRQ_W(8)) u_dut (.ref_clk(ref_clk), .rst(rst),
        .clk_en(clk_en), .lp_req(lp_req), .lp_mode(lp_mode),
        .irq_pin(irq_pin), .core_halted(core_halted),
        .wake_irq(wake_irq), .in_sleep(in_sleep),
        .in_allstop(in_allstop), .gate_en(gate_en),
        .osc_allow(osc_allow));
    lpc_core_model u_core (.ref_clk(ref_clk), .wake_irq(wake_irq),
        .lp_req(lp_req), .lp_mode(lp_mode), .irq_pin(irq_pin));
    function automatic int exp_gate(input int low, input int mode);
        int g;
        g = (low != 0) ? 'h1ffa : 'h1fff;
        if (low != 0 && mode != 0)
            g = g & ~'h1302;
        return g;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        tests_run++;
        if (seen !== want)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish;
        if (fail_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wait_for(input int which);
        n = 0;
        while ((which ? wake_irq : core_halted) !== 1'b1 && n < 30)
        begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    initial
    begin
        ref_clk = 0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            tally_and_finish;
        end
    end
    initial
    begin
        {rst, clk_en} = 2'b11;
        seed = 56;
        fail_count = 0;
        tests_run = 0;
        cycles = 0;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk) rst = 0;
        check(16'(gate_en), 16'h1fff);
        for (i = 0; i < 12; i++)
        begin
            m = (i < 2) ? i[0] : 1'($random(seed));
            u_core.request(m);
            wait_for(0);
            check(16'(n), 16'(lpc_pkg::LPC_SETTLE_CYC));
            check(16'(gate_en), 16'(exp_gate(1, m)));
            check(16'({in_sleep, in_allstop}), {!m, m});
            check(16'(osc_allow), 16'h7f);
            // A second request while halted must be ignored
            u_core.request(!m);
            check(16'(gate_en), 16'(exp_gate(1, m)));
            v = 8'($random(seed)) | 8'h01;
            // Frozen enable: the interrupt must not get through yet
            clk_en = 1'b0;
            u_core.wake(v);
            repeat (8) @(negedge ref_clk);
            check(16'({core_halted, wake_irq}), 16'h2);
            check(16'(gate_en), 16'(exp_gate(1, m)));
            clk_en = 1'b1;
            wait_for(1);
            check(16'(wake_irq), 16'h1);
            check(16'({core_halted, in_sleep, in_allstop}), 16'h0);
            check(16'(gate_en), 16'(exp_gate(0, m)));
            @(negedge ref_clk);
            check(16'(wake_irq), 16'h0);
            repeat (6) @(negedge ref_clk);
        end
        // Reset in mid-run, while halted in all-module clock stop
        u_core.request(1'b1);
        wait_for(0);
        rst = 1'b1;
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        check(16'({core_halted, in_sleep, in_allstop}), 16'h0);
        check(16'(gate_en), 16'(lpc_pkg::LPC_GATE_RST));
        u_core.request(1'b0);
        wait_for(0);
        check(16'(n), 16'(lpc_pkg::LPC_SETTLE_CYC));
        check(16'(gate_en), 16'(exp_gate(1, 0)));
        tally_and_finish;
    end
endmodule
